// ===== design/memory_operand_multiplier.sv
`timescale 1ns/10ps
`default_nettype none
`include "mom_consts.svh"

module memory_operand_multiplier
  import mom_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // instruction issue from the decoder
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  // operand read buses
  input wire logic [15:0] x_operand_i,
  input wire logic [15:0] y_operand_i,
  input wire logic [15:0] data_read_bus_i,
  input wire logic [15:0] coefficient_read_bus_i,
  // result write-back
  output logic result_valid_o,
  output logic [1:0] result_dst_o,
  output logic [39:0] result_o,
  output logic result_ovf_o,
  // avalon-mm slave
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // interrupt
  output logic irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [5:0] ctrl_reg; // mode bits
  logic [1:0] stat_reg; // sticky events
  logic [1:0] mask_reg; // interrupt enables
  logic [3:0] ovf_flag_reg; // accumulator overflow flags
  logic [15:0] temp_reg [4]; // temporary registers
  logic [39:0] acc_reg [4]; // destination accumulators
  logic bus_done_reg; // second cycle of an access

  // mode bits by name
  logic frac_mode;
  logic msat_mode;
  logic rnd_mode;
  logic wide_mode;
  logic sat_mode;
  logic sxt_mode;
  assign frac_mode = ctrl_reg[`MOM_CTRL_FRAC];
  assign msat_mode = ctrl_reg[`MOM_CTRL_MSAT];
  assign rnd_mode = ctrl_reg[`MOM_CTRL_RNDM];
  assign wide_mode = ctrl_reg[`MOM_CTRL_WIDE];
  assign sat_mode = ctrl_reg[`MOM_CTRL_SAT];
  assign sxt_mode = ctrl_reg[`MOM_CTRL_SXT];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  form_type form; // recognised form
  logic [1:0] dst; // destination accumulator
  logic rnd_flag; // round requested
  logic capt_flag; // copy operand to temp three
  logic ures_flag; // unsigned result widening
  logic wide_eff; // effective wide overflow mode
  logic [15:0] capt_val; // value copied to temp three
  logic [16:0] a17; // first multiplier input
  logic [16:0] b17; // second multiplier input
  logic legal; // issued and recognised
  logic illegal; // issued but unknown

  // widen one memory value to 17 bits
  function automatic logic [16:0] widen(input logic [15:0] v, input logic uns,
                                        input logic sxt);
    widen = {(!uns && sxt) & v[15], v};
  endfunction : widen

  // form, fields and operand selection
  always_comb begin
    form = FORM_NONE;
    dst = instr_i[9:8];
    rnd_flag = 1'b0;
    capt_flag = 1'b0;
    ures_flag = 1'b0;
    wide_eff = wide_mode;
    capt_val = data_read_bus_i;
    a17 = 17'h0_0000;
    b17 = 17'h0_0000;
    if (instr_i[31:24] == `MOM_OP_DUAL) begin
      // x times y, each widened by its own tag
      form = FORM_DUAL;
      rnd_flag = instr_i[`MOM_D_RND];
      capt_flag = instr_i[`MOM_D_CAPT];
      capt_val = x_operand_i;
      wide_eff = wide_mode | instr_i[`MOM_D_WIDE];
      a17 = widen(x_operand_i, instr_i[`MOM_D_UNSX], sxt_mode);
      b17 = widen(y_operand_i, instr_i[`MOM_D_UNSY], sxt_mode);
    end else if (instr_i[31:24] == `MOM_OP_TEMP && instr_i[`MOM_S_ONE]) begin
      // temp register times memory, both sign-extended
      form = FORM_TEMP;
      dst = instr_i[13:12];
      rnd_flag = instr_i[`MOM_S_RND];
      capt_flag = instr_i[`MOM_S_CAPT];
      ures_flag = instr_i[`MOM_S_URES];
      a17 = widen(temp_reg[instr_i[9:8]], 1'b0, 1'b1);
      b17 = widen(data_read_bus_i, 1'b0, 1'b1);
    end else if (instr_i[31:24] == `MOM_OP_COEF && !instr_i[15]
                 && instr_i[11:10] == `MOM_C_TAG) begin
      // unit one: data signed, coefficient zero-filled
      form = FORM_COEF;
      dst = instr_i[13:12];
      rnd_flag = instr_i[`MOM_S_RND];
      a17 = widen(data_read_bus_i, 1'b0, 1'b1);
      b17 = widen(coefficient_read_bus_i, 1'b1, 1'b0);
    end
  end

  assign legal = issue_i && form != FORM_NONE;
  assign illegal = issue_i && form == FORM_NONE;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  logic signed [33:0] prod_full; // raw 17x17 product
  logic [31:0] prod32; // shifted and clipped product
  logic [39:0] ext40; // product widened to accumulator
  logic [40:0] rnd41; // rounded with guard bit
  logic ovf; // accumulator overflow
  logic [39:0] res40; // value written back

  assign prod_full = $signed(a17) * $signed(b17);

  // fractional shift and multiply saturation
  always_comb begin
    prod32 = prod_full[31:0];
    if (frac_mode) begin
      prod32 = {prod_full[30:0], 1'b0};
    end
    if (msat_mode && frac_mode && a17 == `MOM_NEG17 && b17 == `MOM_NEG17) begin
      prod32 = `MOM_PROD_MAX;
    end
  end

  // widen to 40 bits, round, detect overflow, saturate
  always_comb begin
    if (ures_flag) begin
      ext40 = {8'h00, prod32};
    end else begin
      ext40 = {{8{prod32[31]}}, prod32};
    end
    rnd41 = {ext40[39], ext40};
    if (rnd_flag) begin
      // rounding mode 0 rounds half up, 1 rounds half to even
      rnd41 = rnd41 + `MOM_RND_HALF;
      if (rnd_mode && ext40[15:0] == `MOM_HALF16) begin
        rnd41[16] = 1'b0;
      end
      rnd41[15:0] = 16'h0000;
    end
    if (wide_eff) begin
      ovf = rnd41[40] != rnd41[39];
    end else begin
      ovf = !(&rnd41[40:31] || ~|rnd41[40:31]);
    end
    res40 = rnd41[39:0];
    if (ovf && sat_mode) begin
      // clip toward the sign of the exact value
      if (wide_eff) begin
        res40 = rnd41[40] ? `MOM_SAT40_NEG : `MOM_SAT40_POS;
      end else begin
        res40 = rnd41[40] ? `MOM_SAT32_NEG : `MOM_SAT32_POS;
      end
    end
  end

  // ----------------------------------------
  // write-back, one result per recognised issue
  // ----------------------------------------
  // accumulators take a new value on every accepted issue
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        acc_reg[i] <= 40'h00_0000_0000;
      end
    end else if (legal) begin
      acc_reg[dst] <= res40;
    end
  end

  // result port mirrors the write-back
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      result_valid_o <= 1'b0;
      result_dst_o <= 2'h0;
      result_o <= 40'h00_0000_0000;
      result_ovf_o <= 1'b0;
    end else begin
      result_valid_o <= legal;
      if (legal) begin
        result_dst_o <= dst;
        result_o <= res40;
        result_ovf_o <= ovf;
      end
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic bus_req; // access pending
  logic bus_fire; // access completes this edge
  logic [31:0] be_mask; // byte-enable bit mask
  logic [31:0] rdata_next; // read mux
  logic stat_rd; // status read completes

  assign bus_req = read_i || write_i;
  assign bus_fire = bus_req && bus_done_reg;
  assign waitrequest_o = bus_req && !bus_done_reg; // one wait state
  assign stat_rd = bus_fire && read_i && address_i == `MOM_ADDR_STAT;
  assign be_mask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // wait-state toggle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bus_done_reg <= 1'b0;
    end else begin
      bus_done_reg <= bus_req && !bus_done_reg;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (address_i == `MOM_ADDR_CTRL) begin
      rdata_next = {26'h000_0000, ctrl_reg};
    end else if (address_i == `MOM_ADDR_STAT) begin
      rdata_next = {30'h0000_0000, stat_reg};
    end else if (address_i == `MOM_ADDR_MASK) begin
      rdata_next = {30'h0000_0000, mask_reg};
    end else if (address_i == `MOM_ADDR_OVF) begin
      rdata_next = {28'h000_0000, ovf_flag_reg};
    end else if (address_i[7:4] == 4'(`MOM_ADDR_TMP >> 4) && address_i[1:0] == 2'h0) begin
      rdata_next = {16'h0000, temp_reg[address_i[3:2]]};
    end else if (address_i[7:5] == 3'(`MOM_ADDR_ACC >> 5) && address_i[1:0] == 2'h0) begin
      if (address_i[2]) begin
        rdata_next = {24'h00_0000, acc_reg[address_i[4:3]][39:32]};
      end else begin
        rdata_next = acc_reg[address_i[4:3]][31:0];
      end
    end
  end

  // read data captured on the first edge, stands for the second
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && !bus_done_reg) begin
      readdata_o <= rdata_next;
    end
  end

  // control and mask writes
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `MOM_CTRL_RST;
      mask_reg <= 2'h0;
    end else if (bus_fire && write_i) begin
      if (address_i == `MOM_ADDR_CTRL) begin
        ctrl_reg <= (ctrl_reg & ~be_mask[5:0]) | (writedata_i[5:0] & be_mask[5:0]);
      end
      if (address_i == `MOM_ADDR_MASK) begin
        mask_reg <= (mask_reg & ~be_mask[1:0]) | (writedata_i[1:0] & be_mask[1:0]);
      end
    end
  end

  // temporary registers: bus writes, capture wins on a clash
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        temp_reg[i] <= 16'h0000;
      end
    end else begin
      if (bus_fire && write_i && address_i[7:4] == 4'(`MOM_ADDR_TMP >> 4)
          && address_i[1:0] == 2'h0) begin
        temp_reg[address_i[3:2]] <= (temp_reg[address_i[3:2]] & ~be_mask[15:0])
                                    | (writedata_i[15:0] & be_mask[15:0]);
      end
      if (legal && capt_flag) begin
        temp_reg[3] <= capt_val;
      end
    end
  end

  // overflow flags: set by overflow, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ovf_flag_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (legal && ovf && dst == i[1:0]) begin
          ovf_flag_reg[i] <= 1'b1;
        end else if (bus_fire && write_i && address_i == `MOM_ADDR_OVF
                     && byteenable_i[0] && writedata_i[i]) begin
          ovf_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // sticky events: a read clears only the bits it returned, new events win
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg[`MOM_EV_OVF] <= (stat_reg[`MOM_EV_OVF]
                                && !(stat_rd && readdata_o[`MOM_EV_OVF])) || (legal && ovf);
      stat_reg[`MOM_EV_ILL] <= (stat_reg[`MOM_EV_ILL]
                                && !(stat_rd && readdata_o[`MOM_EV_ILL])) || illegal;
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_req_wait;
    bus_req && waitrequest_o;
  endsequence
  sequence s_req_done;
    bus_req && !waitrequest_o;
  endsequence

  a_bus_one_wait: assert property (s_req_wait ##1 bus_req |-> s_req_done)
    else $error("access not answered after one wait state");
  a_issue_result: assert property (legal |=> result_valid_o && result_dst_o == $past(dst)
                                   && acc_reg[$past(dst)] == result_o)
    else $error("issue did not produce a result");
  a_frac_shift: assert property (legal && frac_mode && !msat_mode |-> prod32[0] == 1'b0
                                 && prod32[31:1] == prod_full[30:0])
    else $error("fractional shift wrong");
  a_uns_zero: assert property (form == FORM_DUAL && instr_i[`MOM_D_UNSX]
                               |-> a17 == {1'b0, x_operand_i})
    else $error("unsigned operand not zero-filled");
  a_sxt_sign: assert property (form == FORM_DUAL && !instr_i[`MOM_D_UNSY] && sxt_mode
                               |-> b17[16] == y_operand_i[15])
    else $error("operand not sign-extended");
  a_coef_widen: assert property (form == FORM_COEF |-> b17[16] == 1'b0
                                 && a17[16] == data_read_bus_i[15])
    else $error("coefficient form widening wrong");
  a_temp_widen: assert property (form == FORM_TEMP |-> a17[16] == a17[15]
                                 && b17 == {data_read_bus_i[15], data_read_bus_i})
    else $error("temp form widening wrong");
  a_temp_decode: assert property (issue_i && instr_i[31:24] == 8'hD3 && instr_i[10]
                                  |-> form == FORM_TEMP)
    else $error("temp form not recognised");
  a_coef_decode: assert property (issue_i && instr_i[31:24] == 8'hD0 && instr_i[11:10] == 2'h1
                                  && !instr_i[15] |-> form == FORM_COEF)
    else $error("coefficient form not recognised");
  a_msat_clip: assert property (legal && msat_mode && frac_mode && a17 == `MOM_NEG17
                                && b17 == `MOM_NEG17 |-> prod32 == `MOM_PROD_MAX)
    else $error("multiply saturation missed");
  a_ext_width: assert property (legal && !ures_flag |-> ext40[39:32] == {8{prod32[31]}})
    else $error("product not sign-extended");
  a_ures_zero: assert property (legal && ures_flag |-> ext40[39:32] == 8'h00)
    else $error("unsigned result not zero-extended");
  a_round_low: assert property (legal && rnd_flag && !(ovf && sat_mode)
                                |=> result_o[15:0] == 16'h0000)
    else $error("rounded result keeps low bits");
  a_ovf_flag: assert property (legal && ovf |=> ovf_flag_reg[$past(dst)]
                               && stat_reg[`MOM_EV_OVF])
    else $error("overflow flag not set");
  a_sat_narrow: assert property (legal && ovf && sat_mode && !wide_eff
                                 |=> result_o == `MOM_SAT32_POS
                                 || result_o == `MOM_SAT32_NEG)
    else $error("saturation value wrong");
  a_wide_local: assert property (legal && form == FORM_DUAL && instr_i[`MOM_D_WIDE]
                                 && !(bus_fire && write_i) |=> ctrl_reg == $past(ctrl_reg))
    else $error("local wide mode changed the stored mode");
  a_capture_t3: assert property (legal && capt_flag |=> temp_reg[3] == $past(capt_val))
    else $error("temp three not captured");
  a_illegal_event: assert property (illegal |=> stat_reg[`MOM_EV_ILL] && !result_valid_o
                                    && (irq_o || !mask_reg[`MOM_EV_ILL]))
    else $error("unknown opcode not flagged");

endmodule : memory_operand_multiplier
`default_nettype wire

// ===== design/mom_consts.svh
`ifndef MOM_CONSTS_SVH
`define MOM_CONSTS_SVH
// ----------------------------------------
// opcode leading bytes and field positions
// ----------------------------------------
`define MOM_OP_DUAL 8'h86
`define MOM_OP_TEMP 8'hD3
`define MOM_OP_COEF 8'hD0
`define MOM_D_WIDE 4
`define MOM_D_UNSX 3
`define MOM_D_UNSY 2
`define MOM_D_CAPT 1
`define MOM_D_RND 0
`define MOM_S_CAPT 15
`define MOM_S_RND 14
`define MOM_S_URES 11
`define MOM_S_ONE 10
`define MOM_C_TAG 2'h1
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MOM_ADDR_CTRL 8'h00
`define MOM_ADDR_STAT 8'h04
`define MOM_ADDR_MASK 8'h08
`define MOM_ADDR_OVF 8'h0C
`define MOM_ADDR_TMP 8'h10
`define MOM_ADDR_ACC 8'h20
// ----------------------------------------
// control bits, status bits, reset values
// ----------------------------------------
`define MOM_CTRL_FRAC 0
`define MOM_CTRL_MSAT 1
`define MOM_CTRL_RNDM 2
`define MOM_CTRL_WIDE 3
`define MOM_CTRL_SAT 4
`define MOM_CTRL_SXT 5
`define MOM_CTRL_RST 6'h20
`define MOM_EV_OVF 0
`define MOM_EV_ILL 1
// ----------------------------------------
// arithmetic constants
// ----------------------------------------
`define MOM_NEG17 17'h1_8000
`define MOM_PROD_MAX 32'h7FFF_FFFF
`define MOM_RND_HALF 41'h00_0000_8000
`define MOM_HALF16 16'h8000
`define MOM_SAT40_POS 40'h7F_FFFF_FFFF
`define MOM_SAT40_NEG 40'h80_0000_0000
`define MOM_SAT32_POS 40'h00_7FFF_FFFF
`define MOM_SAT32_NEG 40'hFF_8000_0000
`endif

// ===== design/mom_pkg.sv
package mom_pkg;
  // instruction form recognised by the decoder
  typedef enum logic [1:0] {
    FORM_NONE = 2'b00,
    FORM_DUAL = 2'b01,
    FORM_TEMP = 2'b10,
    FORM_COEF = 2'b11
  } form_type;
endpackage : mom_pkg

// ===== testbench/operand_source.sv
`timescale 1ns/10ps
`default_nettype none
`include "mom_consts.svh"
module operand_source (
  // clock
  input wire logic clk_i,
  // instruction issue
  output logic issue_o,
  output logic [31:0] instr_o,
  // operand read buses
  output logic [15:0] x_o,
  output logic [15:0] y_o,
  output logic [15:0] data_o,
  output logic [15:0] coef_o
);
  // ----------------
  // idle values at time zero
  // ----------------
  initial begin
    issue_o = 1'b0;
    instr_o = 32'h0000_0000;
    x_o = 16'h0000;
    y_o = 16'h0000;
    data_o = 16'h0000;
    coef_o = 16'h0000;
  end
  // ----------------
  // issue one instruction, held for reps cycles after gap idle cycles
  // ----------------
  task automatic send(input logic [31:0] instr, input logic [15:0] x, y, d, c,
                      input int reps, input int gap);
    logic [31:0] word;
    word = instr;
    // the coefficient operand is always tagged unsigned
    if (word[31:24] == `MOM_OP_COEF) word[11:10] = `MOM_C_TAG;
    repeat (gap) @(posedge clk_i);
    issue_o <= 1'b1;
    instr_o <= word;
    x_o <= x;
    y_o <= y;
    data_o <= d;
    // coefficient comes from internal memory only, so it never faults
    coef_o <= c;
    repeat (reps) @(posedge clk_i);
    // released buses show the inverse, not a stale value
    issue_o <= 1'b0;
    instr_o <= ~word;
    x_o <= ~x;
    y_o <= ~y;
    data_o <= ~d;
    coef_o <= ~c;
  endtask : send
endmodule : operand_source
`default_nettype wire

// ===== testbench/tb_memory_operand_multiplier.sv
`timescale 1ns/10ps
`default_nettype none
`include "mom_consts.svh"
module tb_memory_operand_multiplier import mom_pkg::*;;
  // ----------------
  // signals
  // ----------------
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  wire logic issue_i;
  wire logic [31:0] instr_i;
  wire logic [15:0] x_operand_i, y_operand_i, data_read_bus_i, coefficient_read_bus_i;
  logic result_valid_o, result_ovf_o, waitrequest_o, irq_o;
  logic [1:0] result_dst_o;
  logic [39:0] result_o;
  logic [31:0] readdata_o;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] byteenable_i = 4'hF;
  int failures = 0;
  int checked = 0;
  int nres = 0;
  int n0;
  int slow = 0;
  logic [39:0] e;
  // ----------------
  // design and instruction source
  // ----------------
  memory_operand_multiplier dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .issue_i(issue_i), .instr_i(instr_i),
    .x_operand_i(x_operand_i), .y_operand_i(y_operand_i), .data_read_bus_i(data_read_bus_i),
    .coefficient_read_bus_i(coefficient_read_bus_i), .result_valid_o(result_valid_o),
    .result_dst_o(result_dst_o), .result_o(result_o), .result_ovf_o(result_ovf_o),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .irq_o(irq_o)
  );
  operand_source src (
    .clk_i(clk_i), .issue_o(issue_i), .instr_o(instr_i), .x_o(x_operand_i),
    .y_o(y_operand_i), .data_o(data_read_bus_i), .coef_o(coefficient_read_bus_i)
  );
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // counts every result pulse
  always @(posedge clk_i) begin
    if (result_valid_o === 1'b1) nres <= nres + 1;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // signed multiply, optional fraction shift and rounding
  function automatic logic [39:0] mulx(input logic signed [16:0] a, b,
                                       input logic frac, rnd, rndm);
    logic signed [39:0] p;
    logic tie;
    p = a * b;
    if (frac) p = p <<< 1;
    tie = (p[15:0] == `MOM_HALF16);
    if (rnd) p = (p + 40'h8000) & ~40'hFFFF;
    // half to even: a tie clears bit 16
    if (rnd && rndm && tie) p[16] = 1'b0;
    return p;
  endfunction : mulx
  function automatic logic [31:0] dop(input logic [1:0] dst, input logic [4:0] f);
    return {`MOM_OP_DUAL, 14'h0, dst, 3'h0, f};
  endfunction : dop
  function automatic logic [31:0] top(input logic cp, rn, input logic [1:0] dst,
                                      input logic ur, input logic [1:0] ts);
    return {`MOM_OP_TEMP, 8'h00, cp, rn, dst, ur, 1'b1, ts, 8'h00};
  endfunction : top
  function automatic logic [31:0] cop(input logic rn, input logic [1:0] dst);
    return {`MOM_OP_COEF, 8'h00, 1'b0, rn, dst, 4'h0, 8'h00};
  endfunction : cop
  // avalon access: hold until waitrequest is seen low, then release
  task automatic bus(input logic wen, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address_i <= a;
    writedata_i <= d;
    write_i <= wen;
    read_i <= !wen;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 64);
    q = readdata_o;
    cmp({39'h0, waitrequest_o}, 40'h0);
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp({8'h00, q}, {8'h00, exp});
  endtask : rd
  // issue one instruction and check the write-back one cycle later
  task automatic op(input logic [31:0] ins, input logic [15:0] x, y, d, c,
                    input logic [1:0] dst, input logic [39:0] exp, input logic ovf);
    src.send(ins, x, y, d, c, 1, slow);
    @(posedge clk_i);
    cmp(result_o, exp);
    cmp({36'h0, result_valid_o, result_ovf_o, result_dst_o}, {36'h0, 1'b1, ovf, dst});
  endtask : op
  task automatic dual(input logic [1:0] dst, input logic [4:0] f, input logic [15:0] x, y,
                      input logic [39:0] exp, input logic ovf);
    op(dop(dst, f), x, y, 16'h0, 16'h0, dst, exp, ovf);
  endtask : dual
  // ----------------
  // watchdog
  // ----------------
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    $display("CHECK FAILED at %0t: run hung", $time);
    wrap_up();
  end
  // ----------------
  // test sequence
  // ----------------
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // reset values and unmapped space
    rd(`MOM_ADDR_CTRL, {26'h0, `MOM_CTRL_RST});
    rd(`MOM_ADDR_STAT, 32'h0);
    rd(`MOM_ADDR_TMP + 8'h0C, 32'h0);
    wr(8'h40, 32'h5555_5555);
    rd(8'h40, 32'h0);
    // dual form widening
    dual(2, 5'h00, 16'h8000, 16'h0002, mulx(17'h1_8000, 2, 0, 0, 0), 0);
    dual(1, 5'h08, 16'h8000, 16'h0002, mulx(17'h0_8000, 2, 0, 0, 0), 0);
    wr(`MOM_ADDR_CTRL, 32'h0000_0000);
    dual(0, 5'h00, 16'h8000, 16'h0002, mulx(17'h0_8000, 2, 0, 0, 0), 0);
    wr(`MOM_ADDR_CTRL, 32'h0000_0021);
    dual(3, 5'h00, 16'h0003, 16'h0005, mulx(3, 5, 1, 0, 0), 0);
    wr(`MOM_ADDR_CTRL, 32'h0000_0023);
    dual(3, 5'h00, 16'h8000, 16'h8000, {8'h00, `MOM_PROD_MAX}, 0);
    // rounding in both modes, and none without the flag
    wr(`MOM_ADDR_CTRL, 32'h0000_0020);
    dual(0, 5'h01, 16'h4000, 16'h0002, mulx(17'h0_4000, 2, 0, 1, 0), 0);
    wr(`MOM_ADDR_CTRL, 32'h0000_0024);
    dual(0, 5'h01, 16'h4000, 16'h0002, mulx(17'h0_4000, 2, 0, 1, 1), 0);
    dual(0, 5'h00, 16'h4000, 16'h0002, mulx(17'h0_4000, 2, 0, 0, 0), 0);
    // overflow, saturation and the local wide mode
    wr(`MOM_ADDR_CTRL, 32'h0000_0030);
    dual(1, 5'h0D, 16'hFFFF, 16'h8000, `MOM_SAT32_POS, 1);
    rd(`MOM_ADDR_OVF, 32'h0000_0002);
    wr(`MOM_ADDR_OVF, 32'h0000_0002);
    rd(`MOM_ADDR_OVF, 32'h0000_0000);
    rd(`MOM_ADDR_STAT, 32'h0000_0001);
    e = mulx(17'h0_FFFF, 17'h0_8000, 0, 1, 0);
    dual(1, 5'h1D, 16'hFFFF, 16'h8000, e, 0);
    rd(`MOM_ADDR_CTRL, 32'h0000_0030);
    wr(`MOM_ADDR_CTRL, 32'h0000_0020);
    wr(`MOM_ADDR_MASK, 32'h0000_0001);
    dual(1, 5'h0D, 16'hFFFF, 16'h8000, e, 1);
    cmp({39'h0, irq_o}, 40'h1);
    rd(`MOM_ADDR_STAT, 32'h0000_0001);
    cmp({39'h0, irq_o}, 40'h0);
    // capture into temporary register three
    dual(0, 5'h02, 16'h1234, 16'h0001, 40'h00_0000_1234, 0);
    rd(`MOM_ADDR_TMP + 8'h0C, 32'h0000_1234);
    // temporary register form
    wr(`MOM_ADDR_TMP + 8'h04, 32'h0000_FFFF);
    e = mulx(17'h1_FFFF, 3, 0, 0, 0);
    op(top(1, 0, 3, 0, 1), 0, 0, 16'h0003, 0, 3, e, 0);
    op(top(0, 1, 3, 0, 1), 0, 0, 16'h0003, 0, 3, mulx(17'h1_FFFF, 3, 0, 1, 0), 0);
    rd(`MOM_ADDR_TMP + 8'h0C, 32'h0000_0003);
    wr(`MOM_ADDR_CTRL, 32'h0000_0028);
    e = mulx(17'h1_FFFF, 1, 0, 0, 0);
    e[39:32] = 8'h00;
    op(top(0, 0, 2, 1, 1), 0, 0, 16'h0001, 0, 2, e, 0);
    wr(`MOM_ADDR_CTRL, 32'h0000_0020);
    // coefficient form from a slow source, accumulator read-only
    slow = 3;
    e = mulx(17'h1_FE00, 17'h0_8000, 0, 0, 0);
    op(cop(0, 3), 0, 0, 16'hFE00, 16'h8000, 3, e, 0);
    slow = 0;
    wr(`MOM_ADDR_ACC + 8'h18, 32'h1234_5678);
    rd(`MOM_ADDR_ACC + 8'h18, 32'hFF00_0000);
    rd(`MOM_ADDR_ACC + 8'h1C, 32'h0000_00FF);
    // unknown opcode, masked and unmasked
    for (int m = 0; m < 2; m++) begin
      wr(`MOM_ADDR_MASK, m ? 32'h0000_0002 : 32'h0000_0000);
      n0 = nres;
      src.send(32'hFF00_0000, 0, 0, 0, 0, 1, 0);
      repeat (2) @(posedge clk_i);
      cmp(40'(nres - n0), 40'h0);
      cmp({39'h0, irq_o}, {39'h0, m[0]});
      rd(`MOM_ADDR_STAT, 32'h0000_0002);
      cmp({39'h0, irq_o}, 40'h0);
    end
    // repeated issue, a full result every cycle
    n0 = nres;
    src.send(dop(2, 5'h00), 16'h0007, 16'h0009, 0, 0, 4, 0);
    @(posedge clk_i);
    #1;
    cmp(result_o, 40'h00_0000_003F);
    cmp(40'(nres - n0), 40'h4);
    @(posedge clk_i);
    wrap_up();
  end
endmodule : tb_memory_operand_multiplier
`default_nettype wire
